// File: logic/hpdc_defines.svh
// Purpose: Constants for the host pin and DMA setup register bank
// Assumes: Included by bare name; definitions only
// Notes: Command codes for the pin setup register are local picks
// Function
// (R1) DMA request pin is active low when bit 5 is 0, high when 1.
// (R2) Bus width field bits 4:3 holds 01 (16-bit bus); other codes reserved.
// (R3) Interrupt pin is active low when bit 2 is 0, high when 1.
// (R4) Interrupt pin is level-signalled when bit 1 is 0, pulsed when 1.
// (R5) Interrupt pin stays disabled while bit 0 is 0; 1 enables it.
// (R6) Processor reads DMA setup with command 21h and writes with A1h.
// (R7) DMA setup is 16 bits, upper byte reserved, lower byte resets zero.
// (R8) Polarity and trigger changes apply next cycle, with no spurious assertion.
`ifndef HPDC_DEFINES_SVH
`define HPDC_DEFINES_SVH

// ****************************************
// Command codes
// ****************************************
`define HPDC_CMD_RD_DMA 8'h21
`define HPDC_CMD_WR_DMA 8'ha1
`define HPDC_CMD_RD_PIN 8'h20
`define HPDC_CMD_WR_PIN 8'ha0

// ****************************************
// Pin setup fields and reset
// ****************************************
`define HPDC_DREQ_POL_BIT 5
`define HPDC_BW_HI 4
`define HPDC_BW_LO 3
`define HPDC_BW_16 2'h1
`define HPDC_IRQ_POL_BIT 2
`define HPDC_IRQ_TRIG_BIT 1
`define HPDC_IRQ_EN_BIT 0
`define HPDC_PIN_RESET 16'h0008

// ****************************************
// DMA setup fields and reset
// ****************************************
`define HPDC_DMA_RESET 16'h0000
`define HPDC_DMA_MASK 16'h00ff
`define HPDC_CNT_EN_BIT 7
`define HPDC_BURST_HI 6
`define HPDC_BURST_LO 5
`define HPDC_RUN_BIT 4
`define HPDC_BUF_HI 3
`define HPDC_BUF_LO 1
`define HPDC_DIR_BIT 0

`endif

// File: logic/hpdc_pkg.sv
// Purpose: Types for the host pin and DMA setup register bank
// Assumes: Compiled before the modules
// Notes: Values live in hpdc_defines.svh
package hpdc_pkg;

  // Which register the data phase addresses
  typedef enum logic [2:0] {
    HPDC_IDLE = 3'b000,
    HPDC_RD_PIN = 3'b001,
    HPDC_WR_PIN = 3'b010,
    HPDC_RD_DMA = 3'b011,
    HPDC_WR_DMA = 3'b100
  } hpdc_state_type;

  typedef struct packed {
    hpdc_state_type state;
    logic [15:0] pin_setup;
    logic [15:0] dma_setup;
    logic [15:0] dout;
    logic doe;
    logic [7:0] dma_fields;
  } hpdc_regs_type;

  typedef struct packed {
    logic req_d;
    logic pin;
  } hpdc_drive_type;

endpackage : hpdc_pkg

// File: logic/hpdc_pin_drive.sv
// Purpose: Shapes one request into a pin level of chosen polarity and trigger
// Assumes: Request comes from logic on the same clock
// Notes: Pin resets to the inactive level of an active-low pin
`timescale 1ns/1ps
`include "hpdc_defines.svh"

module hpdc_pin_drive (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic request,
  input wire logic polarity,
  input wire logic edge_mode,
  output logic pin
);

  hpdc_pkg::hpdc_drive_type st_reg;
  hpdc_pkg::hpdc_drive_type st_next;
  logic active;

  // Level or one-cycle pulse, then polarity; settings act next edge
  always_comb begin
    st_next = st_reg;
    st_next.req_d = request;
    active = edge_mode ? (request & ~st_reg.req_d) : request;
    st_next.pin = polarity ? active : ~active; // R8
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= 2'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin = st_reg.pin;

endmodule : hpdc_pin_drive

// File: logic/hpdc_regs.sv
// Purpose: Pin setup and DMA setup registers behind the 16-bit processor port
// Assumes: Processor port runs on clk; one access per cycle while strobed
// Notes: Command phase with a0 high, data phase with a0 low
`timescale 1ns/1ps
`include "hpdc_defines.svh"

module hpdc_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_cs_n,
  input wire logic bus_a0,
  input wire logic bus_wr_n,
  input wire logic bus_rd_n,
  input wire logic [15:0] bus_din,
  output logic [15:0] bus_dout,
  output logic bus_doe,
  input wire logic irq_source,
  input wire logic processor_irq_enable_reg,
  input wire logic dma_request_source,
  output logic irq_out_a,
  output logic dma_request_out_a,
  output logic transfer_counter_enable,
  output logic [1:0] burst_length,
  output logic dma_run_enable,
  output logic [2:0] buffer_type_select,
  output logic dma_direction
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // Register bank
  // ****************************************
  hpdc_pkg::hpdc_regs_type st_reg;
  hpdc_pkg::hpdc_regs_type st_next;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic irq_request;
  logic dma_request;

  assign cmd_wr = !bus_cs_n && !bus_wr_n && bus_a0;
  assign data_wr = !bus_cs_n && !bus_wr_n && !bus_a0;
  assign data_rd = !bus_cs_n && !bus_rd_n && !bus_a0;

  // Command decode, data phase and register updates
  always_comb begin
    st_next = st_reg;
    st_next.doe = 1'b0;
    if (cmd_wr) begin
      case (bus_din[7:0])
        `HPDC_CMD_RD_DMA: begin // R6
          st_next.state = hpdc_pkg::HPDC_RD_DMA;
          st_next.dout = st_reg.dma_setup;
        end
        `HPDC_CMD_WR_DMA: begin // R6
          st_next.state = hpdc_pkg::HPDC_WR_DMA;
        end
        `HPDC_CMD_RD_PIN: begin
          st_next.state = hpdc_pkg::HPDC_RD_PIN;
          st_next.dout = st_reg.pin_setup;
        end
        `HPDC_CMD_WR_PIN: begin
          st_next.state = hpdc_pkg::HPDC_WR_PIN;
        end
        default: begin
          st_next.state = hpdc_pkg::HPDC_IDLE;
        end
      endcase
    end else if (data_wr) begin
      case (st_reg.state)
        hpdc_pkg::HPDC_WR_PIN: begin
          st_next.pin_setup = bus_din;
          // Reserved width codes are refused; field keeps 16-bit code
          st_next.pin_setup[`HPDC_BW_HI:`HPDC_BW_LO] = `HPDC_BW_16; // R2
          st_next.state = hpdc_pkg::HPDC_IDLE;
        end
        hpdc_pkg::HPDC_WR_DMA: begin
          st_next.dma_setup = bus_din & `HPDC_DMA_MASK; // R7
          st_next.state = hpdc_pkg::HPDC_IDLE;
        end
        default: begin
          st_next.state = st_reg.state;
        end
      endcase
    end else if (data_rd) begin
      case (st_reg.state)
        hpdc_pkg::HPDC_RD_PIN: st_next.doe = 1'b1;
        hpdc_pkg::HPDC_RD_DMA: st_next.doe = 1'b1;
        default: st_next.doe = 1'b0;
      endcase
    end
    st_next.dma_fields = st_next.dma_setup[7:0];
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= {hpdc_pkg::HPDC_IDLE, `HPDC_PIN_RESET, `HPDC_DMA_RESET, 16'h0000, 1'b0, 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // Register-sourced outputs
  assign bus_dout = st_reg.dout;
  assign bus_doe = st_reg.doe;
  assign transfer_counter_enable = st_reg.dma_fields[`HPDC_CNT_EN_BIT];
  assign burst_length = st_reg.dma_fields[`HPDC_BURST_HI:`HPDC_BURST_LO];
  assign dma_run_enable = st_reg.dma_fields[`HPDC_RUN_BIT];
  assign buffer_type_select = st_reg.dma_fields[`HPDC_BUF_HI:`HPDC_BUF_LO];
  assign dma_direction = st_reg.dma_fields[`HPDC_DIR_BIT];

  // ****************************************
  // Pin drivers
  // ****************************************
  // Interrupt gated by global pin enable and processor enable
  assign irq_request = irq_source && processor_irq_enable_reg &&
    st_reg.pin_setup[`HPDC_IRQ_EN_BIT]; // R5
  assign dma_request = dma_request_source && st_reg.dma_setup[`HPDC_RUN_BIT];

  // Interrupt pin shaping
  hpdc_pin_drive u_irq_drive (
    .clk(clk),
    .rst_n(rst_n),
    .request(irq_request),
    .polarity(st_reg.pin_setup[`HPDC_IRQ_POL_BIT]), // R3
    .edge_mode(st_reg.pin_setup[`HPDC_IRQ_TRIG_BIT]), // R4
    .pin(irq_out_a)
  );

  // DMA request pin shaping, always level
  hpdc_pin_drive u_dma_drive (
    .clk(clk),
    .rst_n(rst_n),
    .request(dma_request),
    .polarity(st_reg.pin_setup[`HPDC_DREQ_POL_BIT]), // R1
    .edge_mode(1'b0),
    .pin(dma_request_out_a)
  );

  // ****************************************
  // Assertions
  // ****************************************
  logic irq_pol;
  logic irq_trig;
  logic dreq_pol;
  assign irq_pol = st_reg.pin_setup[`HPDC_IRQ_POL_BIT];
  assign irq_trig = st_reg.pin_setup[`HPDC_IRQ_TRIG_BIT];
  assign dreq_pol = st_reg.pin_setup[`HPDC_DREQ_POL_BIT];

  property p_dreq_pol;
    @(posedge clk) disable iff (!rst_n)
    dma_request |=> (dma_request_out_a == $past(dreq_pol));
  endproperty
  a_dreq_pol: assert property (p_dreq_pol) else $error("DMA request level wrong"); // R1

  property p_bus_width;
    @(posedge clk) disable iff (!rst_n)
    data_wr && st_reg.state == hpdc_pkg::HPDC_WR_PIN |=>
      (st_reg.pin_setup[`HPDC_BW_HI:`HPDC_BW_LO] == `HPDC_BW_16) [*2];
  endproperty
  a_bus_width: assert property (p_bus_width) else $error("Bus width field not 16-bit"); // R2

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
    irq_request && !irq_trig |=> (irq_out_a == $past(irq_pol));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong"); // R3

  property p_irq_pulse;
    @(posedge clk) disable iff (!rst_n)
    irq_trig && irq_request && $past(irq_request) |=> (irq_out_a != $past(irq_pol));
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("Edge interrupt not one pulse"); // R4

  property p_irq_gate;
    @(posedge clk) disable iff (!rst_n)
    !st_reg.pin_setup[`HPDC_IRQ_EN_BIT] |=> (irq_out_a != $past(irq_pol));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Disabled interrupt pin asserted"); // R5

  property p_dma_write;
    @(posedge clk) disable iff (!rst_n)
    data_wr && st_reg.state == hpdc_pkg::HPDC_WR_DMA |=>
      (st_reg.dma_setup == {8'h00, $past(bus_din[7:0])}) &&
      (dma_run_enable == $past(bus_din[`HPDC_RUN_BIT]));
  endproperty
  a_dma_write: assert property (p_dma_write) else $error("DMA setup write wrong"); // R7

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_n)
    !irq_request && !$past(irq_request) |=> (irq_out_a == !$past(irq_pol));
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("Spurious interrupt level"); // R8

  c_dma_rd: cover property (@(posedge clk) disable iff (!rst_n)
    cmd_wr && bus_din[7:0] == `HPDC_CMD_RD_DMA ##[1:4] bus_doe);
  c_irq_edge: cover property (@(posedge clk) disable iff (!rst_n)
    irq_trig && irq_request ##1 irq_request);
  c_dreq_high: cover property (@(posedge clk) disable iff (!rst_n) dreq_pol && dma_request_out_a);

endmodule : hpdc_regs

// File: dv/hpdc_host_model.sv
// Purpose: Processor model that reaches the setup registers over the 16-bit port
// Assumes: Port runs on clk; tasks are called from the bench, one at a time
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/1ps

module hpdc_host_model (
  input wire logic clk,
  output logic bus_cs_n,
  output logic bus_a0,
  output logic bus_wr_n,
  output logic bus_rd_n,
  output logic [15:0] bus_din,
  input wire logic [15:0] bus_dout,
  input wire logic bus_doe
);
  // ****************************************
  // Idle bus
  // ****************************************
  // Deselected at time zero
  initial begin
    bus_cs_n = 1'b1;
    bus_a0 = 1'b1;
    bus_wr_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_din = 16'h0000;
  end

  // Strobes off, data lines no longer hold the old word
  task automatic release_bus();
    bus_cs_n <= 1'b1;
    bus_wr_n <= 1'b1;
    bus_rd_n <= 1'b1;
    bus_a0 <= 1'b1;
    bus_din <= ~bus_din;
  endtask : release_bus

  // ****************************************
  // Accesses
  // ****************************************
  // Command phase: code in the low byte with a0 high
  task automatic cmd_phase(input logic [7:0] code);
    @(posedge clk);
    bus_cs_n <= 1'b0;
    bus_a0 <= 1'b1;
    bus_wr_n <= 1'b0;
    bus_rd_n <= 1'b1;
    bus_din <= {8'h00, code};
  endtask : cmd_phase

  // Command then one data word
  task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
    cmd_phase(code);
    @(posedge clk);
    bus_a0 <= 1'b0;
    bus_din <= data;
    @(posedge clk);
    release_bus();
  endtask : write_reg

  // Command then one read cycle; result is unknown if the port never drives
  task automatic read_reg(input logic [7:0] code, output logic [15:0] data);
    int n;
    cmd_phase(code);
    @(posedge clk);
    bus_a0 <= 1'b0;
    bus_wr_n <= 1'b1;
    bus_rd_n <= 1'b0;
    bus_din <= ~bus_din;
    @(posedge clk);
    release_bus();
    n = 0;
    #1;
    while (bus_doe !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    data = (bus_doe === 1'b1) ? bus_dout : 16'hxxxx;
  endtask : read_reg
endmodule : hpdc_host_model

// File: dv/testbench.sv
// Purpose: Self-checking bench for the pin and DMA setup register bank
// Assumes: Host model drives the port; bench drives the request sources
// Notes: Pin levels are sampled a few cycles after each change
`timescale 1ns/1ps
`include "hpdc_defines.svh"

module testbench;
  logic clk, rstn, cs_n, a0, wr_n, rd_n, doe, irq_src, pie, dreq_src, irq, dreq;
  logic [15:0] din, dout, rd;
  logic cnt_en, run, dir;
  logic [1:0] burst;
  logic [2:0] buf_sel;
  int n_mismatch = 0;
  int comparisons = 0;
  int lows;

  `define CHK(got, exp) check_val(16'(got), 16'(exp))

  // ****************************************
  // Clock, reset, instances
  // ****************************************
  // 10 MHz clock and stimulus start values
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    irq_src = 1'b0;
    pie = 1'b1;
    dreq_src = 1'b0;
  end

  hpdc_host_model host (.clk(clk), .bus_cs_n(cs_n), .bus_a0(a0), .bus_wr_n(wr_n),
    .bus_rd_n(rd_n), .bus_din(din), .bus_dout(dout), .bus_doe(doe));

  hpdc_regs dut (.clk(clk), .rstn(rstn), .bus_cs_n(cs_n), .bus_a0(a0), .bus_wr_n(wr_n),
    .bus_rd_n(rd_n), .bus_din(din), .bus_dout(dout), .bus_doe(doe), .irq_source(irq_src),
    .processor_irq_enable_reg(pie), .dma_request_source(dreq_src), .irq_out_a(irq),
    .dma_request_out_a(dreq), .transfer_counter_enable(cnt_en), .burst_length(burst),
    .dma_run_enable(run), .buffer_type_select(buf_sel), .dma_direction(dir));

  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // Let a pin change land
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // Count cycles with the interrupt pin low
  task automatic count_low(input int cycles);
    lows = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (irq === 1'b0) lows++;
    end
  endtask : count_low

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard, far past the expected run
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values and idle pins
    `CHK(irq, 1'b1);
    `CHK(dreq, 1'b1);
    host.read_reg(`HPDC_CMD_RD_PIN, rd);
    `CHK(rd, `HPDC_PIN_RESET);
    host.read_reg(`HPDC_CMD_RD_DMA, rd);
    `CHK(rd, `HPDC_DMA_RESET);
    $display("test reset done");
    // DMA setup width and field positions
    host.write_reg(`HPDC_CMD_WR_DMA, 16'hffff);
    host.read_reg(`HPDC_CMD_RD_DMA, rd);
    `CHK(rd, 16'h00ff);
    host.write_reg(`HPDC_CMD_WR_DMA, 16'h005a);
    settle();
    `CHK({cnt_en, burst, run, buf_sel, dir}, 8'h5a);
    host.read_reg(`HPDC_CMD_RD_DMA, rd);
    `CHK(rd, 16'h005a);
    $display("test dma_setup done");
    // Reserved bus width refused
    host.write_reg(`HPDC_CMD_WR_PIN, 16'h0010);
    host.read_reg(`HPDC_CMD_RD_PIN, rd);
    `CHK(rd, 16'h0008);
    $display("test bus_width done");
    // Interrupt gate, polarity and trigger; stimulus lands on a rising edge
    @(posedge clk);
    irq_src <= 1'b1;
    settle();
    `CHK(irq, 1'b1);
    host.write_reg(`HPDC_CMD_WR_PIN, 16'h0009);
    settle();
    `CHK(irq, 1'b0);
    @(posedge clk);
    pie <= 1'b0;
    settle();
    `CHK(irq, 1'b1);
    @(posedge clk);
    pie <= 1'b1;
    host.write_reg(`HPDC_CMD_WR_PIN, 16'h000d);
    settle();
    `CHK(irq, 1'b1);
    @(posedge clk);
    irq_src <= 1'b0;
    settle();
    `CHK(irq, 1'b0);
    host.write_reg(`HPDC_CMD_WR_PIN, 16'h000b);
    settle();
    `CHK(irq, 1'b1);
    @(posedge clk);
    irq_src <= 1'b1;
    count_low(8);
    `CHK(lows, 1);
    $display("test irq_pin done");
    // DMA request polarity, with the run bit left set by the dma_setup test
    @(posedge clk);
    dreq_src <= 1'b1;
    settle();
    `CHK(dreq, 1'b0);
    host.write_reg(`HPDC_CMD_WR_PIN, 16'h0028);
    settle();
    `CHK(dreq, 1'b1);
    @(posedge clk);
    dreq_src <= 1'b0;
    settle();
    `CHK(dreq, 1'b0);
    $display("test dma_request done");
    tally_and_finish();
  end
endmodule : testbench
